// ==== shared/reload_timer_defs.svh ====
// constants for the split-capable auto-reload timer
// Overview of operation
// - split_mode_enable clear: one 16-bit counter; set: two 8-bit counters.
// - 16-bit wrap from 0xffff loads both reload bytes and sets high_overflow_flag.
// - 16-bit mode with timer interrupt enabled: request on every full overflow.
// - 16-bit mode, low irq enable set: also request on each low byte wrap.
// - split mode: each byte reloads from its own reload byte on its overflow.
// - split mode: run_control gates only the high byte; low byte always counts.
// - byte clock: sys_clk_a select set uses system clock, else div12 or ext/8.
// - external clock divided by 8 is synchronised; it must not exceed system clock.
// - split mode: high byte wrap 0xff to 0x00 sets high_overflow_flag.
// - split mode: low byte wrap 0xff to 0x00 sets low_overflow_flag.
// - split mode: request on high wraps, and on low wraps when enabled.
// - overflow flags are only ever cleared by software writing zero.
// - low byte sys_clk_a select clocks whole timer in 16-bit mode, low byte in split.
// - high byte sys_clk_a select matters only in split mode.
`ifndef RELOAD_TIMER_DEFS_SVH
`define RELOAD_TIMER_DEFS_SVH

// register addresses on the special function register port
`define RT_ADDR_CONTROL 8'h91
`define RT_ADDR_RELOAD_LO 8'h92
`define RT_ADDR_RELOAD_HI 8'h93
`define RT_ADDR_COUNT_LO 8'h94
`define RT_ADDR_COUNT_HI 8'h95

// timer_control field positions
`define RT_BIT_HIGH_FLAG 7
`define RT_BIT_LOW_FLAG 6
`define RT_BIT_LOW_IRQ_EN 5
`define RT_BIT_SPLIT 3
`define RT_BIT_RUN 2
`define RT_BIT_EXT_SEL 0

// reset values
`define RT_RESET_CONTROL 8'h00
`define RT_RESET_BYTE 8'h00

// prescaler counts
`define RT_DIV_SYS 12
`define RT_DIV_EXT 8

`endif

// ==== shared/reload_timer_pkg.sv ====
// types shared by the split-capable auto-reload timer
package reload_timer_pkg;
  typedef logic [7:0] sfr_addr_t;
  typedef logic [7:0] sfr_data_t;
  // counting mode, one-hot
  typedef enum logic [1:0] {
    MODE_WIDE = 2'b01,
    MODE_SPLIT = 2'b10
  } timer_mode_e;
endpackage

// ==== shared/timer_tick_if.sv ====
// prescaled tick strobes passed from the tick source to the timer core
`timescale 1ns/1ns
`default_nettype none
interface timer_tick_if;
  logic div12Tick; // one-cycle pulse every twelve system clocks
  logic ext8Tick; // one-cycle pulse every eighth external rising edge
  modport src (output div12Tick, output ext8Tick);
  modport sink (input div12Tick, input ext8Tick);
endinterface
`default_nettype wire

// ==== src/tick_source.sv ====
// prescalers: system clock divided by 12 and synchronised external clock divided by 8
`timescale 1ns/1ns
`default_nettype none
`include "reload_timer_defs.svh"
module tick_source #(
  parameter int unsigned SYS_DIV = `RT_DIV_SYS,
  parameter int unsigned EXT_DIV = `RT_DIV_EXT
) (
  input wire logic clock, // system clock
  input wire logic resetn, // async reset, active low
  input wire logic extClkIn, // external oscillator level
  timer_tick_if.src ticks // prescaled strobes
);
  logic [3:0] sysCnt_ff, nxt_sysCnt;
  logic [2:0] extCnt_ff, nxt_extCnt;
  logic extMeta_ff, extSync_ff, extPrev_ff;
  logic div12_ff, nxt_div12;
  logic ext8_ff, nxt_ext8;
  logic extRise;

  // edge found on the second stage only; the first stage feeds nothing else
  always_comb begin
    extRise = extSync_ff & ~extPrev_ff;
    nxt_div12 = (sysCnt_ff == 4'(SYS_DIV - 1));
    nxt_sysCnt = nxt_div12 ? 4'h0 : sysCnt_ff + 4'h1;
    nxt_ext8 = extRise && (extCnt_ff == 3'(EXT_DIV - 1));
    nxt_extCnt = extRise ? extCnt_ff + 3'h1 : extCnt_ff;
  end

  // registers only; an ext clock faster than the system clock would drop edges
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sysCnt_ff <= 4'h0;
      extCnt_ff <= 3'h0;
      extMeta_ff <= 1'b0;
      extSync_ff <= 1'b0;
      extPrev_ff <= 1'b0;
      div12_ff <= 1'b0;
      ext8_ff <= 1'b0;
    end else begin
      sysCnt_ff <= nxt_sysCnt;
      extCnt_ff <= nxt_extCnt;
      extMeta_ff <= extClkIn;
      extSync_ff <= extMeta_ff;
      extPrev_ff <= extSync_ff;
      div12_ff <= nxt_div12;
      ext8_ff <= nxt_ext8;
    end
  end

  assign ticks.div12Tick = div12_ff;
  assign ticks.ext8Tick = ext8_ff;
endmodule // tick_source
`default_nettype wire

// ==== src/reload_timer_16_split_8.sv ====
// auto-reload timer: one 16-bit counter or two 8-bit counters, with sfr port
`timescale 1ns/1ns
`default_nettype none
`include "reload_timer_defs.svh"
module reload_timer_16_split_8 (
  input wire logic clock, // system clock, 125 MHz
  input wire logic resetn, // async reset, active low
  input wire reload_timer_pkg::sfr_addr_t sfrAddr, // register address
  input wire logic sfrWrite, // write strobe
  input wire reload_timer_pkg::sfr_data_t sfrWdata, // write data
  input wire logic sfrRead, // read strobe
  output reload_timer_pkg::sfr_data_t sfrRdata, // read data, one cycle after strobe
  input wire logic lowSysClkSel, // low byte uses system clock
  input wire logic highSysClkSel, // high byte uses system clock in split mode
  input wire logic timerIrqEnable, // timer interrupt enable
  input wire logic extClkIn, // external oscillator level
  output logic irqRequest // interrupt request level
);
  import reload_timer_pkg::*;

  timer_tick_if ticks ();

  logic hiFlag_ff, nxt_hiFlag;
  logic loFlag_ff, nxt_loFlag;
  logic loIrqEn_ff, nxt_loIrqEn;
  logic split_ff, nxt_split;
  logic run_ff, nxt_run;
  logic extSel_ff, nxt_extSel;
  logic [7:0] reloadLo_ff, nxt_reloadLo;
  logic [7:0] reloadHi_ff, nxt_reloadHi;
  logic [7:0] cntLo_ff, nxt_cntLo;
  logic [7:0] cntHi_ff, nxt_cntHi;
  sfr_data_t rdata_ff, nxt_rdata;
  logic irq_ff, nxt_irq;

  logic lowTick, highTick, setHi, setLo, ctrlWr;
  logic [15:0] wideSum;
  timer_mode_e mode;
  sfr_data_t ctrlView;

  tick_source #(
    .SYS_DIV(`RT_DIV_SYS),
    .EXT_DIV(`RT_DIV_EXT)
  ) u_ticks (
    .clock(clock),
    .resetn(resetn),
    .extClkIn(extClkIn),
    .ticks(ticks)
  );

  // address match, used by every write and read decode
  function automatic logic sfrHit(input sfr_addr_t addr, input sfr_addr_t off);
    sfrHit = (addr == off);
  endfunction

  // count source per byte: system clock, or div12 / ext div8 by the ext select
  function automatic logic tickSel(input logic sysSel, input logic extSel, input logic d12, input logic e8);
    if (sysSel) begin
      tickSel = 1'b1;
    end else if (extSel) begin
      tickSel = e8;
    end else begin
      tickSel = d12;
    end
  endfunction

  // byte tick selection
  always_comb begin
    mode = split_ff ? MODE_SPLIT : MODE_WIDE;
    lowTick = tickSel(lowSysClkSel, extSel_ff, ticks.div12Tick, ticks.ext8Tick);
    // high select ignored in wide mode, so both bytes share the low clock
    if (split_ff) begin
      highTick = tickSel(highSysClkSel, extSel_ff, ticks.div12Tick, ticks.ext8Tick);
    end else begin
      highTick = lowTick;
    end
    ctrlWr = sfrWrite && sfrHit(sfrAddr, `RT_ADDR_CONTROL);
  end

  // counting and reload
  always_comb begin
    nxt_cntLo = cntLo_ff;
    nxt_cntHi = cntHi_ff;
    setHi = 1'b0;
    setLo = 1'b0;
    wideSum = {cntHi_ff, cntLo_ff} + 16'h0001;
    case (mode)
      MODE_WIDE: begin
        // hold while stopped, one step per selected tick while running
        if (run_ff && lowTick) begin
          if (cntLo_ff == 8'hff) begin
            setLo = 1'b1; // low byte wrap flagged in either mode
          end
          if ({cntHi_ff, cntLo_ff} == 16'hffff) begin
            nxt_cntLo = reloadLo_ff;
            nxt_cntHi = reloadHi_ff;
            setHi = 1'b1;
          end else begin
            nxt_cntLo = wideSum[7:0];
            nxt_cntHi = wideSum[15:8];
          end
        end
      end
      MODE_SPLIT: begin
        // low byte is free running, run bit does not gate it
        if (lowTick) begin
          if (cntLo_ff == 8'hff) begin
            nxt_cntLo = reloadLo_ff;
            setLo = 1'b1;
          end else begin
            nxt_cntLo = cntLo_ff + 8'h01;
          end
        end
        if (run_ff && highTick) begin
          if (cntHi_ff == 8'hff) begin
            nxt_cntHi = reloadHi_ff;
            setHi = 1'b1;
          end else begin
            nxt_cntHi = cntHi_ff + 8'h01;
          end
        end
      end
      default: begin
        nxt_cntLo = cntLo_ff;
        nxt_cntHi = cntHi_ff;
      end
    endcase
    // a software write to a count byte overrides the step in that cycle
    if (sfrWrite && sfrHit(sfrAddr, `RT_ADDR_COUNT_LO)) begin
      nxt_cntLo = sfrWdata;
    end
    if (sfrWrite && sfrHit(sfrAddr, `RT_ADDR_COUNT_HI)) begin
      nxt_cntHi = sfrWdata;
    end
  end

  // control and reload registers; hardware set beats a same-cycle software clear
  always_comb begin
    nxt_hiFlag = hiFlag_ff;
    nxt_loFlag = loFlag_ff;
    nxt_loIrqEn = loIrqEn_ff;
    nxt_split = split_ff;
    nxt_run = run_ff;
    nxt_extSel = extSel_ff;
    nxt_reloadLo = reloadLo_ff;
    nxt_reloadHi = reloadHi_ff;
    if (ctrlWr) begin
      nxt_hiFlag = sfrWdata[`RT_BIT_HIGH_FLAG];
      nxt_loFlag = sfrWdata[`RT_BIT_LOW_FLAG];
      nxt_loIrqEn = sfrWdata[`RT_BIT_LOW_IRQ_EN];
      nxt_split = sfrWdata[`RT_BIT_SPLIT];
      nxt_run = sfrWdata[`RT_BIT_RUN];
      nxt_extSel = sfrWdata[`RT_BIT_EXT_SEL];
    end
    // hardware only ever sets the flags here, never clears them; software writes above set or clear them
    nxt_hiFlag = nxt_hiFlag | setHi;
    nxt_loFlag = nxt_loFlag | setLo;
    if (sfrWrite && sfrHit(sfrAddr, `RT_ADDR_RELOAD_LO)) begin
      nxt_reloadLo = sfrWdata;
    end
    if (sfrWrite && sfrHit(sfrAddr, `RT_ADDR_RELOAD_HI)) begin
      nxt_reloadHi = sfrWdata;
    end
  end

  // interrupt level from the sticky flags; handler sorts out the source
  always_comb begin
    nxt_irq = timerIrqEnable && (hiFlag_ff || (loFlag_ff && loIrqEn_ff));
  end

  // read mux; unused control bits read as zero, unmapped addresses as zero
  always_comb begin
    ctrlView = 8'h00;
    ctrlView[`RT_BIT_HIGH_FLAG] = hiFlag_ff;
    ctrlView[`RT_BIT_LOW_FLAG] = loFlag_ff;
    ctrlView[`RT_BIT_LOW_IRQ_EN] = loIrqEn_ff;
    ctrlView[`RT_BIT_SPLIT] = split_ff;
    ctrlView[`RT_BIT_RUN] = run_ff;
    ctrlView[`RT_BIT_EXT_SEL] = extSel_ff;
    nxt_rdata = 8'h00;
    if (sfrRead) begin
      if (sfrHit(sfrAddr, `RT_ADDR_CONTROL)) begin
        nxt_rdata = ctrlView;
      end else if (sfrHit(sfrAddr, `RT_ADDR_RELOAD_LO)) begin
        nxt_rdata = reloadLo_ff;
      end else if (sfrHit(sfrAddr, `RT_ADDR_RELOAD_HI)) begin
        nxt_rdata = reloadHi_ff;
      end else if (sfrHit(sfrAddr, `RT_ADDR_COUNT_LO)) begin
        nxt_rdata = cntLo_ff;
      end else if (sfrHit(sfrAddr, `RT_ADDR_COUNT_HI)) begin
        nxt_rdata = cntHi_ff;
      end else begin
        nxt_rdata = 8'h00;
      end
    end
  end

  // state registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hiFlag_ff <= 1'b0;
      loFlag_ff <= 1'b0;
      loIrqEn_ff <= 1'b0;
      split_ff <= 1'b0;
      run_ff <= 1'b0;
      extSel_ff <= 1'b0;
      reloadLo_ff <= `RT_RESET_BYTE;
      reloadHi_ff <= `RT_RESET_BYTE;
      cntLo_ff <= `RT_RESET_BYTE;
      cntHi_ff <= `RT_RESET_BYTE;
      rdata_ff <= 8'h00;
      irq_ff <= 1'b0;
    end else begin
      hiFlag_ff <= nxt_hiFlag;
      loFlag_ff <= nxt_loFlag;
      loIrqEn_ff <= nxt_loIrqEn;
      split_ff <= nxt_split;
      run_ff <= nxt_run;
      extSel_ff <= nxt_extSel;
      reloadLo_ff <= nxt_reloadLo;
      reloadHi_ff <= nxt_reloadHi;
      cntLo_ff <= nxt_cntLo;
      cntHi_ff <= nxt_cntHi;
      rdata_ff <= nxt_rdata;
      irq_ff <= nxt_irq;
    end
  end

  assign sfrRdata = rdata_ff;
  assign irqRequest = irq_ff;
endmodule // reload_timer_16_split_8
`default_nettype wire

// ==== verification/reload_timer_monitor.sv ====
// port assertions for the reload timer
`timescale 1ns/1ns
`default_nettype none
module reload_timer_monitor (
  input wire logic clock, // clock
  input wire logic resetn, // reset, low
  input wire reload_timer_pkg::sfr_addr_t sfrAddr, // address
  input wire logic sfrWrite, // write
  input wire reload_timer_pkg::sfr_data_t sfrWdata, // wdata
  input wire logic sfrRead, // read
  input wire reload_timer_pkg::sfr_data_t sfrRdata, // rdata
  input wire logic lowSysClkSel, // low select
  input wire logic highSysClkSel, // high select
  input wire logic timerIrqEnable, // irq enable
  input wire logic extClkIn, // ext clock
  input wire logic irqRequest // request
);
  import reload_timer_pkg::*;
  sfr_data_t ctl_ff;
  sfr_data_t nxt_ctl;
  // shadow of control; hardware never moves its mode bits
  always_comb begin
    nxt_ctl = ctl_ff;
    if (sfrWrite && sfrAddr == 8'h91) nxt_ctl = sfrWdata;
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) ctl_ff <= 8'h00;
    else ctl_ff <= nxt_ctl;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // a clean read, and two of them two cycles apart
  sequence rdAt(logic [7:0] a, logic c);
    c && sfrRead && !sfrWrite && sfrAddr == a;
  endsequence
  sequence rdPair(logic [7:0] a, logic c, logic m);
    rdAt(a, c) ##1 (m && !sfrWrite) ##1 rdAt(a, m);
  endsequence
  unmapped_zero_a: assert property (sfrRead && (sfrAddr < 8'h91 || sfrAddr > 8'h95) |=> sfrRdata == 8'h00)
    else $error("unmapped read not zero");
  spare_bits_a: assert property (rdAt(8'h91, 1'b1) |=> sfrRdata[4] == 1'b0 && sfrRdata[1] == 1'b0)
    else $error("unused control bit set");
  mode_readback_a: assert property (rdAt(8'h91, 1'b1) |=> (sfrRdata & 8'h2d) == ($past(ctl_ff) & 8'h2d))
    else $error("control bits lost");
  irq_enable_a: assert property (irqRequest |-> $past(timerIrqEnable))
    else $error("request without enable");
  flag_sticky_a: assert property (
    $fell(irqRequest) |-> $past(!timerIrqEnable) || $past(sfrWrite && sfrAddr == 8'h91, 2))
    else $error("request dropped by hardware");
  low_hold_a: assert property (rdPair(8'h94, !ctl_ff[3] && !ctl_ff[2], 1'b1) |=> sfrRdata == $past(sfrRdata, 2))
    else $error("stopped counter moved");
  high_hold_a: assert property (rdPair(8'h95, !ctl_ff[2], 1'b1) |=> sfrRdata == $past(sfrRdata, 2))
    else $error("stopped high byte moved");
  low_step_a: assert property (
    rdPair(8'h94, (ctl_ff[3] || ctl_ff[2]) && lowSysClkSel, lowSysClkSel) |=>
    sfrRdata == 8'($past(sfrRdata, 2) + 8'h02) || $past(sfrRdata, 2) >= 8'hfe)
    else $error("low byte not one per clock");
endmodule // reload_timer_monitor
`default_nettype wire

// ==== verification/testbench.sv ====
// self-checking bench for the reload timer
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checksDone++; if ((g) !== (e)) begin nErrors++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module testbench;
  import reload_timer_pkg::*;
  logic clock, resetn, sfrWrite, sfrRead, lowSysClkSel, highSysClkSel, timerIrqEnable, extClkIn, irqRequest;
  sfr_addr_t sfrAddr;
  sfr_data_t sfrWdata, sfrRdata, d;
  bit extOn;
  int nErrors, checksDone, cyc, tk, t0, ts, rl, m, n, st;
  localparam logic [7:0] CTAB [4] = '{8'h40, 8'h60, 8'he0, 8'h00};
  reload_timer_16_split_8 DUT (.*);
  // 8 ns clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // cycle count; external clock well below system clock
  always @(posedge clock) begin
    if (!resetn) begin
      cyc <= 0;
      extClkIn <= 1'b0;
    end else begin
      cyc <= cyc + 1;
      if (extOn && cyc % 3 == 0) extClkIn <= ~extClkIn;
    end
  end
  // one register access; tk is its taking edge
  task automatic bus(input logic w, input sfr_addr_t a, input sfr_data_t v);
    @(posedge clock);
    {sfrWrite, sfrRead, sfrAddr, sfrWdata} <= {w, !w, a, v};
    @(posedge clock);
    tk = cyc;
    {sfrWrite, sfrRead} <= 2'b00;
    @(negedge clock);
    d = sfrRdata;
  endtask
  task automatic rc(input sfr_addr_t a, input int e);
    bus(1'b0, a, 8'h00);
    `CHK($sformatf("reg %h", a), e, d)
  endtask
  // counter model: wraps load the reload value; bit 16 wrap, bit 17 low byte wrap
  function automatic int adv(int v, int r, int k, int top);
    int f;
    f = 0;
    for (int i = 0; i < k; i++) begin
      if ((v & 255) == 255) f |= 2;
      if (v == top) begin
        v = r;
        f |= 1;
      end else v++;
    end
    return v | (f << 16);
  endfunction
  task automatic finish_test;
    $display("checks %0d errors %0d", checksDone, nErrors);
    if (nErrors == 0 && checksDone > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    void'($urandom(33389));
    {resetn, sfrWrite, sfrRead, sfrAddr, sfrWdata, lowSysClkSel, highSysClkSel, timerIrqEnable} = '0;
    {extOn, nErrors, checksDone} = '0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    // reset values; a stray unmapped write changes nothing
    bus(1'b1, 8'h90, 8'hff);
    for (int a = 8'h90; a <= 8'h96; a++) rc(8'(a), 0);
    // flags set and cleared by software, and the request
    @(posedge clock) timerIrqEnable <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 8'h91, CTAB[i]);
      rc(8'h91, CTAB[i]);
      `CHK("irq", i == 1 || i == 2, irqRequest)
    end
    // 16-bit counting over a low wrap, then a full wrap
    // low reload byte kept below 0x80 so no wrap lands on a flag-clearing write
    rl = $urandom & 16'hff7f;
    bus(1'b1, 8'h92, rl[7:0]);
    bus(1'b1, 8'h93, rl[15:8]);
    @(posedge clock) lowSysClkSel <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      st = s ? 16'hfff8 : 16'h00f8;
      @(posedge clock) highSysClkSel <= 1'($urandom);
      bus(1'b1, 8'h94, st[7:0]);
      bus(1'b1, 8'h95, st[15:8]);
      bus(1'b1, 8'h91, 8'h24);
      t0 = tk;
      repeat (4) bus(1'b0, 8'h94, 8'h00);
      bus(1'b0, 8'h91, 8'h00);
      `CHK("ctrl", {1'(adv(st, rl, tk - t0 - 1, 16'hffff) >> 16), 1'b1, 6'h24}, d)
      `CHK("irq", 1'b1, irqRequest)
      bus(1'b1, 8'h91, 8'h20);
      m = adv(st, rl, tk - t0, 16'hffff);
      rc(8'h94, m & 8'hff);
      rc(8'h94, m & 8'hff);
      rc(8'h95, m >> 8 & 8'hff);
      `CHK("irq", 1'b0, irqRequest)
    end
    // split: low byte free-running, high byte under run control
    @(posedge clock) highSysClkSel <= 1'b1;
    bus(1'b1, 8'h95, 8'hfc);
    bus(1'b1, 8'h94, 8'hfb);
    bus(1'b1, 8'h91, 8'h08);
    ts = tk;
    rc(8'h95, 8'hfc);
    rc(8'h95, 8'hfc);
    rc(8'h91, 8'h48);
    `CHK("irq", 1'b0, irqRequest)
    bus(1'b1, 8'h91, 8'h2c);
    t0 = tk;
    repeat (3) bus(1'b0, 8'h94, 8'h00);
    bus(1'b0, 8'h91, 8'h00);
    `CHK("flags", 8'hac, d)
    `CHK("irq", 1'b1, irqRequest)
    // enable dropped while a flag stands: request falls, flag stays
    @(posedge clock) timerIrqEnable <= 1'b0;
    bus(1'b0, 8'h91, 8'h00);
    `CHK("irq", 1'b0, irqRequest)
    `CHK("hi flag", 1'b1, d[7])
    @(posedge clock) timerIrqEnable <= 1'b1;
    bus(1'b1, 8'h91, 8'h08);
    rc(8'h95, adv(8'hfc, rl >> 8, tk - t0, 8'hff) & 8'hff);
    bus(1'b0, 8'h94, 8'h00);
    `CHK("low", adv(8'hfb, rl & 8'hff, tk - ts - 1, 8'hff) & 8'hff, d)
    // divided sources: system clock by 12, external clock by 8
    @(posedge clock) lowSysClkSel <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      extOn = k[0];
      bus(1'b1, 8'h91, 8'h00);
      bus(1'b1, 8'h94, 8'h00);
      bus(1'b1, 8'h95, 8'h00);
      bus(1'b1, 8'h91, 8'(4 + k));
      t0 = tk;
      repeat (k ? 500 : 130) @(posedge clock);
      bus(1'b0, 8'h94, 8'h00);
      n = (tk - t0 - 1) / (k ? 48 : 12);
      `CHK("ticks", 1'b1, d + 1 >= n && d <= n + 1)
      rc(8'h95, 0);
    end
    finish_test;
  end
endmodule // testbench
bind reload_timer_16_split_8 reload_timer_monitor mon (.*);
`default_nettype wire
